// ---- pkg/ipa_pkg.sv ----
// Constants and types shared by the interrupt pin and acknowledge logic
package ipa_pkg;

    // ==========================================
    // Sizes
    localparam int NUM_EXT = 4;
    localparam int VEC_W = 8;
    localparam int NUM_W = 4;
    localparam int SEL_W = 5;

    // ==========================================
    // Vector positions
    localparam int VEC_RESET = 0;
    localparam int VEC_NMI = 1;
    localparam int VEC_RSVD2 = 2;
    localparam int VEC_RSVD3 = 3;
    localparam int VEC_EXT_BASE = 4;

    // ==========================================
    // Default selector codes of the external pins
    localparam logic [SEL_W-1:0] SEL_EXT0 = 5'h04;
    localparam logic [SEL_W-1:0] SEL_EXT1 = 5'h05;
    localparam logic [SEL_W-1:0] SEL_EXT2 = 5'h06;
    localparam logic [SEL_W-1:0] SEL_EXT3 = 5'h07;

    // ==========================================
    // Acknowledge timing
    localparam int ACK_CYCLES = 2;

    // ==========================================
    // Reset values
    localparam logic [VEC_W-1:0] VEC_REQ_RST = 8'h00;
    localparam logic [NUM_W-1:0] NUM_RST = 4'h0;
    localparam logic STRAP_SYNC_RST = 1'b1;
    localparam logic SCAN_MODE_RST = 1'b0;

    // ==========================================
    // Acknowledge state machine
    typedef enum logic [0:0] {
        ACK_IDLE = 1'b0,
        ACK_BUSY = 1'b1
    } ipa_ack_state_t;

endpackage

// ---- design/ipa_edge_detect.sv ----
// Synchronised edge detector with selectable active edge
`timescale 1ns/1ps
`default_nettype none
module ipa_edge_detect
    import ipa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pin and edge choice
    input wire logic pin,
    input wire logic falling_sel,
    // Detected edge
    output logic edge_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [1:0] prime_cnt_reg;
    logic primed_reg;
    logic edge_next;

    // ==========================================
    // Two-stage synchroniser
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
        end
    end

    // ==========================================
    // History; judging waits until history holds a real pin sample
    // A pin already high at release must not look like an edge
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_reg <= 1'b0;
            prime_cnt_reg <= 2'h0;
            primed_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= sync2_reg;
            if (prime_cnt_reg != 2'h2)
                prime_cnt_reg <= prime_cnt_reg + 2'h1;
            primed_reg <= primed_reg | (prime_cnt_reg == 2'h2);
        end
    end

    always_comb
    begin
        if (falling_sel)
            edge_next = primed_reg & prev_reg & ~sync2_reg;
        else
            edge_next = primed_reg & ~prev_reg & sync2_reg;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            edge_pulse <= 1'b0;
        else
            edge_pulse <= edge_next;
    end

endmodule
`default_nettype wire

// ---- design/ipa_top.sv ----
// Interrupt pin front end, acknowledge outputs and emulation strap capture
// Contract
// RULE1 - Non-maskable input raises one request per rising edge, never on level.
// RULE2 - Four external inputs edge-detected, each edge chosen by its polarity bit.
// RULE3 - Acknowledge strobe asserts whenever the core starts servicing any interrupt; here a start while the strobe is high is ignored.
// RULE4 - Four-bit number names the serviced interrupt, valid throughout the strobe.
// RULE5 - Number equals the interrupt's position in service fetch-packet ordering.
// RULE6 - Both straps low selects boundary scan; both high selects emulation/normal.
// RULE7 - Vectors zero to three are fixed, unmaskable and not reassignable.
// RULE8 - External pins feed vectors four to seven via codes 00100 to 00111.
// RULE9 - Number stays stable for the whole time the strobe is high.
`timescale 1ns/1ps
`default_nettype none
module ipa_top
    import ipa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Interrupt pins
    input wire logic nmi_in,
    input wire logic ext_irq_in_0,
    input wire logic ext_irq_in_1,
    input wire logic ext_irq_in_2,
    input wire logic ext_irq_in_3,
    // Polarity control, bit set means falling edge
    input wire logic [NUM_EXT-1:0] ext_irq_polarity_field,
    // Requests to the core, one bit per vector
    output logic [VEC_W-1:0] vec_req,
    // Core service start
    input wire logic core_service_start,
    input wire logic [NUM_W-1:0] core_service_vec,
    // Acknowledge outputs
    output logic irq_ack_strobe,
    output logic [NUM_W-1:0] serviced_irq_number,
    // Emulation strap pins
    input wire logic emul_strap_0_in,
    output logic emul_strap_0_out,
    output logic emul_strap_0_oe,
    input wire logic emul_strap_1_in,
    output logic emul_strap_1_out,
    output logic emul_strap_1_oe,
    // Test mode
    output logic boundary_scan_mode,
    output logic strap_mismatch,
    output logic strap_valid
);

    logic nmi_edge;
    logic [NUM_EXT-1:0] ext_pin;
    logic [NUM_EXT-1:0] ext_edge;
    logic [SEL_W-1:0] ext_sel [NUM_EXT];
    logic [VEC_W-1:0] vec_req_next;
    ipa_ack_state_t ack_state_reg;
    ipa_ack_state_t ack_state_next;
    logic [1:0] ack_cnt_reg;
    logic [NUM_W-1:0] ack_num_reg;
    logic [1:0] s0_sync_reg;
    logic [1:0] s1_sync_reg;
    logic emu_drv_reg;

    assign ext_pin = {ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0};
    assign ext_sel[0] = SEL_EXT0;
    assign ext_sel[1] = SEL_EXT1;
    assign ext_sel[2] = SEL_EXT2;
    assign ext_sel[3] = SEL_EXT3;

    // ==========================================
    // Edge detection
    ipa_edge_detect u_nmi_edge
    (
        .mclk(mclk),
        .rstn(rstn),
        .pin(nmi_in),
        .falling_sel(1'b0), // RULE1
        .edge_pulse(nmi_edge)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi = gi + 1)
        begin : g_ext
            ipa_edge_detect u_ext_edge
            (
                .mclk(mclk),
                .rstn(rstn),
                .pin(ext_pin[gi]),
                .falling_sel(ext_irq_polarity_field[gi]), // RULE2
                .edge_pulse(ext_edge[gi])
            );
        end
    endgenerate

    // ==========================================
    // Vector routing; low four vectors fixed
    always_comb
    begin
        vec_req_next = VEC_REQ_RST;
        vec_req_next[VEC_NMI] = nmi_edge; // RULE1 RULE7
        for (int i = 0; i < NUM_EXT; i++)
        begin
            for (int v = 0; v < NUM_EXT; v++)
            begin
                if (ext_sel[v] == SEL_W'(VEC_EXT_BASE + i))
                    vec_req_next[VEC_EXT_BASE + v] = vec_req_next[VEC_EXT_BASE + v] | ext_edge[i]; // RULE8
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            vec_req <= VEC_REQ_RST;
        else
            vec_req <= vec_req_next;
    end

    // ==========================================
    // Acknowledge sequencing
    always_comb
    begin
        ack_state_next = ack_state_reg;
        case (ack_state_reg)
            ACK_IDLE:
            begin
                if (core_service_start)
                    ack_state_next = ACK_BUSY; // RULE3
            end
            ACK_BUSY:
            begin
                if (ack_cnt_reg == 2'(ACK_CYCLES - 1))
                    ack_state_next = ACK_IDLE;
            end
            default:
            begin
                ack_state_next = ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ack_state_reg <= ACK_IDLE;
        else
            ack_state_reg <= ack_state_next;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ack_cnt_reg <= 2'h0;
        else if (ack_state_reg == ACK_BUSY)
            ack_cnt_reg <= ack_cnt_reg + 2'h1;
        else
            ack_cnt_reg <= 2'h0;
    end

    // Number latched at start only, held through the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ack_num_reg <= NUM_RST;
        else if (ack_state_reg == ACK_IDLE && core_service_start)
            ack_num_reg <= core_service_vec; // RULE4 RULE5 RULE9
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            irq_ack_strobe <= 1'b0;
        else
            irq_ack_strobe <= (ack_state_next == ACK_BUSY); // RULE3
    end

    assign serviced_irq_number = ack_num_reg; // RULE4

    // ==========================================
    // Emulation strap capture
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s0_sync_reg <= {2{STRAP_SYNC_RST}};
            s1_sync_reg <= {2{STRAP_SYNC_RST}};
        end
        else
        begin
            s0_sync_reg <= {s0_sync_reg[0], emul_strap_0_in};
            s1_sync_reg <= {s1_sync_reg[0], emul_strap_1_in};
        end
    end

    // Caught once after synchroniser has filled
    logic [1:0] strap_wait_reg;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_wait_reg <= 2'h0;
            strap_valid <= 1'b0;
            boundary_scan_mode <= SCAN_MODE_RST;
            strap_mismatch <= 1'b0;
        end
        else if (!strap_valid)
        begin
            if (strap_wait_reg == 2'h2)
            begin
                strap_valid <= 1'b1;
                boundary_scan_mode <= ~s0_sync_reg[1] & ~s1_sync_reg[1]; // RULE6
                strap_mismatch <= s0_sync_reg[1] ^ s1_sync_reg[1];
            end
            else
                strap_wait_reg <= strap_wait_reg + 2'h1;
        end
    end

    // Strap pins are only sensed here
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            emu_drv_reg <= 1'b0;
        else
            emu_drv_reg <= 1'b0;
    end

    assign emul_strap_0_out = emu_drv_reg;
    assign emul_strap_0_oe = emu_drv_reg;
    assign emul_strap_1_out = emu_drv_reg;
    assign emul_strap_1_oe = emu_drv_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence svc_start_s;
        core_service_start && ack_state_reg == ACK_IDLE;
    endsequence

    sequence ack_window_s;
        irq_ack_strobe [*2] ##1 !irq_ack_strobe;
    endsequence

    chk_nmi_vector: assert property (nmi_edge |=> vec_req[VEC_NMI]) // RULE1
        else $error("nmi edge did not raise its vector");
    chk_nmi_single: assert property (vec_req[VEC_NMI] |=> !vec_req[VEC_NMI]) // RULE1
        else $error("nmi request longer than one cycle");
    chk_nmi_cause: assert property (vec_req[VEC_NMI] |-> $past(nmi_edge)) // RULE1
        else $error("nmi request without edge");

    generate
        for (gi = 0; gi < NUM_EXT; gi = gi + 1)
        begin : g_chk
            chk_ext_route: assert property (ext_edge[gi] |=> vec_req[VEC_EXT_BASE + gi]) // RULE8
                else $error("external edge not on its vector");
            chk_ext_cause: assert property (vec_req[VEC_EXT_BASE + gi] |-> $past(ext_edge[gi])) // RULE2
                else $error("external request without edge");
        end
    endgenerate

    chk_fixed_low: assert property (!vec_req[VEC_RESET] && !vec_req[VEC_RSVD2] && !vec_req[VEC_RSVD3]) // RULE7
        else $error("fixed low vector asserted");
    chk_ack_start: assert property (svc_start_s |=> ack_window_s) // RULE3
        else $error("acknowledge strobe not two cycles");
    chk_ack_number: assert property (svc_start_s |=> serviced_irq_number == $past(core_service_vec)) // RULE4
        else $error("serviced number wrong");
    chk_num_stable: assert property (irq_ack_strobe && $past(irq_ack_strobe) |-> $stable(serviced_irq_number)) // RULE9
        else $error("number changed during strobe");
    chk_strap_mode: assert property ($rose(strap_valid) |-> boundary_scan_mode == (!$past(s0_sync_reg[1]) && !$past(s1_sync_reg[1]))) // RULE6
        else $error("test mode not from strap levels");
    chk_strap_hold: assert property (strap_valid && $past(strap_valid) |-> $stable(boundary_scan_mode)) // RULE6
        else $error("test mode changed after capture");

endmodule
`default_nettype wire

// ---- verif/ipa_board_model.sv ----
// Board-side model: interrupt sources, strap pull resistors and acknowledge watch
`timescale 1ns/1ps
`default_nettype none
module ipa_board_model
    import ipa_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Strap pull direction fitted on the board
    input wire logic [1:0] strap_pull,
    // Strap pin drivers of the device
    input wire logic emul_strap_0_out,
    input wire logic emul_strap_0_oe,
    input wire logic emul_strap_1_out,
    input wire logic emul_strap_1_oe,
    // Acknowledge outputs watched
    input wire logic irq_ack_strobe,
    input wire logic [NUM_W-1:0] serviced_irq_number,
    // Pins driven by the board
    output logic nmi_in,
    output logic [NUM_EXT-1:0] ext_pins,
    output logic emul_strap_0_in,
    output logic emul_strap_1_in,
    // Number moved while strobe was high
    output logic ack_unstable
);
    logic strobe_prev;
    logic [NUM_W-1:0] num_prev;

    initial
    begin
        nmi_in = 1'b0;
        ext_pins = '0;
        ack_unstable = 1'b0;
    end

    // Pin level: device driver when enabled, otherwise the pull resistor
    assign emul_strap_0_in = emul_strap_0_oe ? emul_strap_0_out : strap_pull[0];
    assign emul_strap_1_in = emul_strap_1_oe ? emul_strap_1_out : strap_pull[1];

    // Index NUM_EXT selects the non-maskable pin
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge mclk);
        #1;
        if (idx == NUM_EXT)
            nmi_in = lvl;
        else
            ext_pins[idx] = lvl;
    endtask

    always @(posedge mclk)
    begin
        strobe_prev <= irq_ack_strobe;
        num_prev <= serviced_irq_number;
        if (strobe_prev === 1'b1 && irq_ack_strobe === 1'b1 && num_prev !== serviced_irq_number)
            ack_unstable <= 1'b1;
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the interrupt pin and acknowledge logic
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ipa_pkg::*;
;
    logic mclk;
    logic rstn;
    logic [NUM_EXT-1:0] pol;
    logic core_service_start;
    logic [NUM_W-1:0] core_service_vec;
    logic [1:0] strap_pull;
    wire logic nmi_in;
    wire logic [NUM_EXT-1:0] ext_pins;
    wire logic [VEC_W-1:0] vec_req;
    wire logic irq_ack_strobe;
    wire logic [NUM_W-1:0] serviced_irq_number;
    wire logic s0_in, s0_out, s0_oe, s1_in, s1_out, s1_oe;
    wire logic boundary_scan_mode, strap_mismatch, strap_valid, ack_unstable;
    int fail_count = 0;
    int checks = 0;

    ipa_top ipa_top_i (.mclk(mclk), .rstn(rstn), .nmi_in(nmi_in), .ext_irq_in_0(ext_pins[0]),
        .ext_irq_in_1(ext_pins[1]), .ext_irq_in_2(ext_pins[2]), .ext_irq_in_3(ext_pins[3]),
        .ext_irq_polarity_field(pol), .vec_req(vec_req), .core_service_start(core_service_start),
        .core_service_vec(core_service_vec), .irq_ack_strobe(irq_ack_strobe),
        .serviced_irq_number(serviced_irq_number), .emul_strap_0_in(s0_in), .emul_strap_0_out(s0_out),
        .emul_strap_0_oe(s0_oe), .emul_strap_1_in(s1_in), .emul_strap_1_out(s1_out),
        .emul_strap_1_oe(s1_oe), .boundary_scan_mode(boundary_scan_mode),
        .strap_mismatch(strap_mismatch), .strap_valid(strap_valid));

    ipa_board_model ipa_board_model_i (.mclk(mclk), .strap_pull(strap_pull), .emul_strap_0_out(s0_out),
        .emul_strap_0_oe(s0_oe), .emul_strap_1_out(s1_out), .emul_strap_1_oe(s1_oe),
        .irq_ack_strobe(irq_ack_strobe), .serviced_irq_number(serviced_irq_number), .nmi_in(nmi_in),
        .ext_pins(ext_pins), .emul_strap_0_in(s0_in), .emul_strap_1_in(s1_in),
        .ack_unstable(ack_unstable));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset with a board strap setting, then judge the captured mode
    task automatic do_reset(input logic [1:0] straps);
        int n;
        n = 0;
        rstn = 1'b0;
        strap_pull = straps;
        repeat (4) @(posedge mclk);
        #1;
        rstn = 1'b1;
        while (strap_valid !== 1'b1)
        begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 10)
            begin
                fail_count++;
                tally_and_finish();
            end
        end
        check({2'h0, s0_out, s1_out, s0_oe, s1_oe, strap_mismatch, boundary_scan_mode},
            {6'h00, straps[0] ^ straps[1], straps == 2'b00});
    endtask

    // Count pulses on one request bit; fixed reset and reserved vectors stay quiet
    task automatic count_req(input int b, input int n, output int cnt);
        cnt = 0;
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            if (vec_req[b] === 1'b1)
                cnt++;
            check({5'h00, vec_req[3:2], vec_req[0]}, 8'h00);
        end
    endtask

    task automatic nmi_scenario();
        int c;
        ipa_board_model_i.set_pin(NUM_EXT, 1'b1);
        count_req(VEC_NMI, 8, c);
        check(8'(c), 8'h01);
        count_req(VEC_NMI, 12, c);
        check(8'(c), 8'h00);
        ipa_board_model_i.set_pin(NUM_EXT, 1'b0);
        count_req(VEC_NMI, 8, c);
        check(8'(c), 8'h00);
    endtask

    task automatic ext_scenario();
        int c;
        for (int i = 0; i < NUM_EXT; i++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                @(posedge mclk);
                #1;
                pol[i] = p[0];
                count_req(VEC_EXT_BASE + i, 4, c);
                check(8'(c), 8'h00);
                ipa_board_model_i.set_pin(i, 1'b1);
                count_req(VEC_EXT_BASE + i, 8, c);
                check(8'(c), {7'h00, p == 0});
                ipa_board_model_i.set_pin(i, 1'b0);
                count_req(VEC_EXT_BASE + i, 8, c);
                check(8'(c), {7'h00, p == 1});
            end
        end
    endtask

    // One service start; optionally a second start during the strobe
    task automatic ack_one(input logic [NUM_W-1:0] v, input logic refuse);
        core_service_start = 1'b1;
        core_service_vec = v;
        @(posedge mclk);
        #1;
        core_service_start = refuse;
        core_service_vec = ~v;
        check({irq_ack_strobe, 3'h0, serviced_irq_number}, {1'b1, 3'h0, v});
        @(posedge mclk);
        #1;
        core_service_start = 1'b0;
        check({irq_ack_strobe, 3'h0, serviced_irq_number}, {1'b1, 3'h0, v});
        @(posedge mclk);
        #1;
        check({irq_ack_strobe, 3'h0, serviced_irq_number}, {1'b0, 3'h0, v});
    endtask

    // Pin already high at reset release must not count as an edge
    task automatic reset_high_scenario();
        int c;
        ipa_board_model_i.set_pin(NUM_EXT, 1'b1);
        do_reset(2'b01);
        count_req(VEC_NMI, 8, c);
        check(8'(c), 8'h00);
        ipa_board_model_i.set_pin(NUM_EXT, 1'b0);
    endtask

    task automatic ack_scenario();
        for (int v = 0; v < 16; v++)
            ack_one(v[NUM_W-1:0], v == 7 || v == 15);
        check({7'h00, ack_unstable}, 8'h00);
    endtask

    initial
    begin
        rstn = 1'b0;
        pol = '0;
        core_service_start = 1'b0;
        core_service_vec = '0;
        strap_pull = 2'b11;
        do_reset(2'b11);
        nmi_scenario();
        ext_scenario();
        ack_scenario();
        do_reset(2'b00);
        reset_high_scenario();
        do_reset(2'b10);
        tally_and_finish();
    end
endmodule
`default_nettype wire
